// >>> src/fop_pkg.sv
package fop_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_OPTION  = 3'h0;
  localparam logic [2:0] IDX_POWER   = 3'h2;
  localparam logic [2:0] IDX_STATUS  = 3'h3;
  localparam logic [2:0] IDX_STANDBY = 3'h4;
  localparam logic [2:0] IDX_ACTIVE  = 3'h5;
  localparam logic [2:0] IDX_BANK    = 3'h6;
  localparam logic [2:0] IDX_OTP     = 3'h7;

  // Field positions
  localparam int RANDOM_LSB = 0;
  localparam int PAGE_LSB   = 4;

  // Values after reset
  localparam logic [3:0] RANDOM_RST  = 4'hf;
  localparam logic [3:0] PAGE_RST    = 4'hf;
  localparam logic [4:0] OTPW_RST    = 5'h1f;
  localparam logic [7:0] STANDBY_RST = 8'hff;
  localparam logic [7:0] ACTIVE_RST  = 8'hff;

  // Fixed wait count for password words
  localparam logic [4:0] PWD_WAITS   = 5'h10;

  // Memory map in 16-bit word addresses
  localparam logic [21:0] FLASH_LO = 22'h3f0000;
  localparam logic [21:0] FLASH_HI = 22'h3f7fff;
  localparam logic [21:0] OTP_LO   = 22'h3d7800;
  localparam logic [21:0] OTP_HI   = 22'h3d7bff;
  localparam logic [21:0] PWD_LO   = 22'h3f7ff8;
  localparam logic [21:0] PWD_HI   = 22'h3f7fff;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power modes, Gray along sleep, standby, active
  typedef enum logic [1:0] {
    PWR_SLEEP   = 2'h0,
    PWR_STANDBY = 2'h1,
    PWR_ACTIVE  = 2'h3
  } fop_pwr_t;
  localparam logic [1:0] PWR_RESERVED = 2'h2;

  // Access engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0,
    ENG_PREP = 2'h1,
    ENG_ARR  = 2'h3
  } fop_eng_t;

  typedef enum logic [1:0] {
    KIND_FETCH = 2'h0,
    KIND_READ  = 2'h1,
    KIND_WRITE = 2'h2
  } fop_kind_t;

  typedef struct packed {
    logic        valid;
    fop_kind_t   kind;
    logic        disc;
    logic        secure_zone;
    logic [21:0] addr;
  } fop_cpu_req_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fop_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fop_axi_rsp_t;

endpackage : fop_pkg

// >>> src/fop_ctrl.sv
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
module fop_ctrl (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  input  wire fop_pkg::fop_axi_req_t axi_req,
  output fop_pkg::fop_axi_rsp_t      axi_rsp,
  input  wire fop_pkg::fop_cpu_req_t cpu_req,
  output logic                       cpu_ack,
  output logic [63:0]                cpu_rdata,
  input  wire logic                  csm_locked,
  output logic                       arr_en,
  output logic [19:0]                arr_addr,
  input  wire logic [63:0]           arr_rdata,
  output logic [1:0]                 pwr_state
);

  fop_pkg::fop_axi_rsp_t axi_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        opt_en_r;
  logic [3:0]  rand_w_r;
  logic [3:0]  page_w_r;
  logic [4:0]  otp_w_r;
  logic [7:0]  stby_w_r;
  logic [7:0]  act_w_r;
  logic        pw_wr_r;
  logic [1:0]  pw_val_r;
  fop_pkg::fop_pwr_t pwr_r;
  fop_pkg::fop_pwr_t tgt_r;
  logic        waking_r;
  logic [7:0]  wcnt_r;
  fop_pkg::fop_eng_t eng_r;
  logic [4:0]  ecnt_r;
  logic        e_pf_r;
  logic [19:0] e_addr_r;
  logic        arr_en_r;
  logic        cpu_ack_r;
  logic [63:0] rdata_r;
  logic        disc_done_r;
  logic        row_ok_r;
  logic [14:0] row_r;
  logic [1:0]  bval_r;
  logic [19:0] baddr_r [2];
  logic [63:0] bdata_r [2];
  logic [19:0] pf_next_r;
  logic        pf_on_r;

  // Region and wait-count decode on 64-bit word addresses
  function automatic logic in_region(input logic [19:0] a);
    in_region = ({a, 2'h0} >= fop_pkg::FLASH_LO && {a, 2'h0} <= fop_pkg::FLASH_HI) ||
                ({a, 2'h0} >= fop_pkg::OTP_LO && {a, 2'h0} <= fop_pkg::OTP_HI);
  endfunction : in_region

  function automatic logic is_otp(input logic [19:0] a);
    is_otp = {a, 2'h0} >= fop_pkg::OTP_LO && {a, 2'h0} <= fop_pkg::OTP_HI;
  endfunction : is_otp

  function automatic logic is_pwd(input logic [19:0] a);
    is_pwd = {a, 2'h3} >= fop_pkg::PWD_LO && {a, 2'h0} <= fop_pkg::PWD_HI;
  endfunction : is_pwd

  // Request decode; the CPU holds a request until it sees the ack
  logic [19:0] a64;
  logic        serve;
  logic        req_rg;
  logic        wr_c;
  logic        abort_c;
  logic        pipe_c;
  logic        hit0_c;
  logic        hit1_c;
  logic        miss_c;
  logic        dem_c;
  logic        pf_go_c;
  logic        zero_c;
  logic        wake_req;
  logic [4:0]  waits_c;
  logic [19:0] pf_inc;

  assign a64     = cpu_req.addr[21:2];
  assign serve   = cpu_req.valid && !cpu_ack_r;
  assign req_rg  = in_region(a64);
  assign wr_c    = serve && req_rg && cpu_req.kind == fop_pkg::KIND_WRITE;
  assign pipe_c  = serve && opt_en_r && cpu_req.kind == fop_pkg::KIND_FETCH;
  assign abort_c = pipe_c && cpu_req.disc && !disc_done_r;
  assign hit0_c  = pipe_c && req_rg && bval_r[0] && baddr_r[0] == a64;
  assign hit1_c  = pipe_c && req_rg && !hit0_c && bval_r[1] && baddr_r[1] == a64;
  assign miss_c  = pipe_c && req_rg && !hit0_c && !hit1_c && eng_r == fop_pkg::ENG_IDLE &&
                   !(pf_on_r && pf_next_r == a64 && !bval_r[1]);
  assign dem_c   = serve && req_rg && (cpu_req.kind == fop_pkg::KIND_READ ||
                   (cpu_req.kind == fop_pkg::KIND_FETCH && !opt_en_r));
  assign pf_go_c = opt_en_r && pf_on_r && !bval_r[1] && !miss_c;
  assign zero_c  = csm_locked && !cpu_req.secure_zone;
  assign wake_req = eng_r == fop_pkg::ENG_PREP && pwr_r != fop_pkg::PWR_ACTIVE;
  assign pf_inc  = e_addr_r + 20'h1;

  // Password first, then OTP, then row hit or miss
  always_comb
  begin
    if (is_pwd(e_addr_r))
      waits_c = fop_pkg::PWD_WAITS;
    else if (is_otp(e_addr_r))
      waits_c = fop_pkg::OTPW_RST & otp_w_r;
    else if (row_ok_r && row_r == e_addr_r[19:5])
      waits_c = {1'b0, page_w_r};
    else
      waits_c = {1'b0, rand_w_r};
  end

  // AXI4-Lite slave with register writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      axi_r     <= '0;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      opt_en_r  <= 1'b0;
      rand_w_r  <= fop_pkg::RANDOM_RST;
      page_w_r  <= fop_pkg::PAGE_RST;
      otp_w_r   <= fop_pkg::OTPW_RST;
      stby_w_r  <= fop_pkg::STANDBY_RST;
      act_w_r   <= fop_pkg::ACTIVE_RST;
      pw_wr_r   <= 1'b0;
      pw_val_r  <= 2'h0;
    end
    else if (ce)
    begin
      pw_wr_r       <= 1'b0;
      axi_r.awready <= !aw_held_r && !axi_r.bvalid && !(axi_req.awvalid && axi_r.awready);
      axi_r.wready  <= !w_held_r && !axi_r.bvalid && !(axi_req.wvalid && axi_r.wready);
      if (axi_req.awvalid && axi_r.awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_r.wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= axi_req.wdata;
        wstrb_r  <= axi_req.wstrb;
      end
      // Write commits once both halves are held
      if (aw_held_r && w_held_r && !axi_r.bvalid)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        axi_r.bvalid <= 1'b1;
        axi_r.bresp  <= fop_pkg::RESP_OKAY;
        if (awaddr_r[1:0] != 2'h0 || awaddr_r[7:5] != 3'h0 || awaddr_r[4:2] == 3'h1)
          axi_r.bresp <= fop_pkg::RESP_SLVERR;
        else if (wstrb_r[0])
        begin
          if (awaddr_r[4:2] == fop_pkg::IDX_OPTION)
            opt_en_r <= wdata_r[0];
          else if (awaddr_r[4:2] == fop_pkg::IDX_POWER)
          begin
            pw_wr_r  <= 1'b1;
            pw_val_r <= wdata_r[1:0];
          end
          else if (awaddr_r[4:2] == fop_pkg::IDX_STANDBY)
            stby_w_r <= wdata_r[7:0];
          else if (awaddr_r[4:2] == fop_pkg::IDX_ACTIVE)
            act_w_r <= wdata_r[7:0];
          else if (awaddr_r[4:2] == fop_pkg::IDX_BANK)
          begin
            rand_w_r <= wdata_r[fop_pkg::RANDOM_LSB +: 4];
            page_w_r <= wdata_r[fop_pkg::PAGE_LSB +: 4];
          end
          else if (awaddr_r[4:2] == fop_pkg::IDX_OTP)
            otp_w_r <= wdata_r[4:0];
        end
      end
      else if (axi_r.bvalid && axi_req.bready)
        axi_r.bvalid <= 1'b0;
      // Read path, one outstanding read
      if (axi_r.rvalid && axi_req.rready)
      begin
        axi_r.rvalid  <= 1'b0;
        axi_r.arready <= 1'b1;
      end
      else if (!axi_r.rvalid && !axi_r.arready)
        axi_r.arready <= 1'b1;
      else if (axi_req.arvalid && axi_r.arready)
      begin
        axi_r.arready <= 1'b0;
        axi_r.rvalid  <= 1'b1;
        axi_r.rresp   <= fop_pkg::RESP_OKAY;
        axi_r.rdata   <= 32'h0000_0000;
        if (axi_req.araddr[1:0] != 2'h0 || axi_req.araddr[7:5] != 3'h0 || axi_req.araddr[4:2] == 3'h1)
          axi_r.rresp <= fop_pkg::RESP_SLVERR;
        else if (axi_req.araddr[4:2] == fop_pkg::IDX_OPTION)
          axi_r.rdata <= {31'h0, opt_en_r};
        else if (axi_req.araddr[4:2] == fop_pkg::IDX_POWER)
          axi_r.rdata <= {30'h0, pwr_r};
        else if (axi_req.araddr[4:2] == fop_pkg::IDX_STATUS)
          axi_r.rdata <= {28'h0, bval_r, pf_on_r, waking_r};
        else if (axi_req.araddr[4:2] == fop_pkg::IDX_STANDBY)
          axi_r.rdata <= {24'h0, stby_w_r};
        else if (axi_req.araddr[4:2] == fop_pkg::IDX_ACTIVE)
          axi_r.rdata <= {24'h0, act_w_r};
        else if (axi_req.araddr[4:2] == fop_pkg::IDX_BANK)
          axi_r.rdata <= {24'h0, page_w_r, rand_w_r};
        else
          axi_r.rdata <= {27'h0, otp_w_r};
      end
    end
  end

  // Power sequencer; modes compare numerically as sleep < standby < active
  logic pw_ok;
  logic pw_lower;
  logic pw_higher;
  logic [1:0] step_c;
  assign pw_ok     = pw_wr_r && pw_val_r != fop_pkg::PWR_RESERVED;
  assign pw_lower  = pw_ok && pw_val_r < pwr_r;
  assign pw_higher = pw_ok && pw_val_r > pwr_r;
  assign step_c    = (pwr_r == fop_pkg::PWR_SLEEP) ? fop_pkg::PWR_STANDBY : fop_pkg::PWR_ACTIVE;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_r    <= fop_pkg::PWR_SLEEP;
      tgt_r    <= fop_pkg::PWR_SLEEP;
      waking_r <= 1'b0;
      wcnt_r   <= 8'h00;
    end
    else if (ce)
    begin
      if (pw_lower)
      begin
        pwr_r    <= fop_pkg::fop_pwr_t'(pw_val_r);
        tgt_r    <= fop_pkg::fop_pwr_t'(pw_val_r);
        waking_r <= 1'b0;
      end
      else
      begin
        if (pw_higher)
          tgt_r <= fop_pkg::fop_pwr_t'(pw_val_r);
        else if (wake_req)
          tgt_r <= fop_pkg::PWR_ACTIVE;
        if (!waking_r && (pw_higher || wake_req))
        begin
          waking_r <= 1'b1;
          wcnt_r   <= (pwr_r == fop_pkg::PWR_SLEEP) ? stby_w_r : act_w_r;
        end
        else if (waking_r)
        begin
          if (wcnt_r == 8'h00)
          begin
            pwr_r <= fop_pkg::fop_pwr_t'(step_c);
            if (step_c == tgt_r)
              waking_r <= 1'b0;
            else
              wcnt_r <= act_w_r;
          end
          else
            wcnt_r <= wcnt_r - 8'h01;
        end
      end
    end
  end

  // Access engine, prefetch buffer and CPU answers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      eng_r       <= fop_pkg::ENG_IDLE;
      ecnt_r      <= 5'h00;
      e_pf_r      <= 1'b0;
      e_addr_r    <= 20'h00000;
      arr_en_r    <= 1'b0;
      cpu_ack_r   <= 1'b0;
      rdata_r     <= 64'h0;
      disc_done_r <= 1'b0;
      row_ok_r    <= 1'b0;
      row_r       <= 15'h0000;
      bval_r      <= 2'h0;
      baddr_r     <= '{default: 20'h00000};
      bdata_r     <= '{default: 64'h0};
      pf_next_r   <= 20'h00000;
      pf_on_r     <= 1'b0;
    end
    else if (ce)
    begin
      cpu_ack_r <= 1'b0;
      if (cpu_ack_r)
        disc_done_r <= 1'b0;
      if (pwr_r != fop_pkg::PWR_ACTIVE)
        row_ok_r <= 1'b0;
      // CPU side: write drop, abort, buffer hits, misses
      if (wr_c)
      begin
        cpu_ack_r <= 1'b1;
        rdata_r   <= 64'h0;
      end
      else if (abort_c)
      begin
        bval_r      <= 2'h0;
        disc_done_r <= 1'b1;
        pf_next_r   <= a64;
        pf_on_r     <= req_rg;
        if (e_pf_r && eng_r != fop_pkg::ENG_IDLE)
        begin
          eng_r    <= fop_pkg::ENG_IDLE;
          arr_en_r <= 1'b0;
        end
      end
      else if (hit0_c)
      begin
        cpu_ack_r <= 1'b1;
        rdata_r   <= zero_c ? 64'h0 : bdata_r[0];
      end
      else if (hit1_c)
      begin
        cpu_ack_r  <= 1'b1;
        rdata_r    <= zero_c ? 64'h0 : bdata_r[1];
        bval_r     <= {1'b0, bval_r[1]};
        baddr_r[0] <= baddr_r[1];
        bdata_r[0] <= bdata_r[1];
      end
      else if (miss_c)
      begin
        bval_r    <= 2'h0;
        pf_next_r <= a64;
        pf_on_r   <= 1'b1;
      end
      // Engine; data reads only start from idle, so they wait out a prefetch
      if (!abort_c)
      begin
        case (eng_r)
          fop_pkg::ENG_IDLE:
          begin
            if (dem_c)
            begin
              e_addr_r <= a64;
              e_pf_r   <= 1'b0;
              eng_r    <= fop_pkg::ENG_PREP;
            end
            else if (pf_go_c)
            begin
              e_addr_r <= pf_next_r;
              e_pf_r   <= 1'b1;
              eng_r    <= fop_pkg::ENG_PREP;
            end
          end
          fop_pkg::ENG_PREP:
          begin
            if (pwr_r == fop_pkg::PWR_ACTIVE)
            begin
              ecnt_r   <= waits_c;
              arr_en_r <= 1'b1;
              eng_r    <= fop_pkg::ENG_ARR;
              row_ok_r <= !is_otp(e_addr_r);
              row_r    <= e_addr_r[19:5];
            end
          end
          fop_pkg::ENG_ARR:
          begin
            if (ecnt_r == 5'h00)
            begin
              arr_en_r <= 1'b0;
              eng_r    <= fop_pkg::ENG_IDLE;
              if (e_pf_r)
              begin
                bval_r[bval_r[0]]  <= 1'b1;
                baddr_r[bval_r[0]] <= e_addr_r;
                bdata_r[bval_r[0]] <= arr_rdata;
                pf_next_r          <= pf_inc;
                pf_on_r            <= in_region(pf_inc);
              end
              else
              begin
                cpu_ack_r <= 1'b1;
                rdata_r   <= zero_c ? 64'h0 : arr_rdata;
              end
            end
            else
              ecnt_r <= ecnt_r - 5'h01;
          end
          default:
            eng_r <= fop_pkg::ENG_IDLE;
        endcase
      end
    end
  end

  assign axi_rsp   = axi_r;
  assign cpu_ack   = cpu_ack_r;
  assign cpu_rdata = rdata_r;
  assign arr_en    = arr_en_r;
  assign arr_addr  = e_addr_r;
  assign pwr_state = pwr_r;

  // Checks
  sequence s_enter_arr;
    eng_r == fop_pkg::ENG_PREP && pwr_r == fop_pkg::PWR_ACTIVE && ce;
  endsequence

  sequence s_pwd_enter;
    s_enter_arr and is_pwd(e_addr_r);
  endsequence

  a_write_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_c && ce) |=> cpu_ack_r)
    else $error("write not acked next cycle");

  a_lower_now: assert property (@(posedge clk) disable iff (!arst_n)
    (pw_lower && ce) |=> (pwr_r == $past(pw_val_r)))
    else $error("lower power mode not immediate");

  a_stall_wake: assert property (@(posedge clk) disable iff (!arst_n)
    (pwr_r != fop_pkg::PWR_ACTIVE) |-> !arr_en_r)
    else $error("array accessed while not active");

  a_pwd_sixteen: assert property (@(posedge clk) disable iff (!arst_n)
    s_pwd_enter |=> (ecnt_r == 5'h10))
    else $error("password wait count not sixteen");

  a_otp_waits: assert property (@(posedge clk) disable iff (!arst_n)
    (s_enter_arr and (is_otp(e_addr_r) && !is_pwd(e_addr_r))) |=> (ecnt_r == otp_w_r))
    else $error("otp wait count wrong");

  a_page_waits: assert property (@(posedge clk) disable iff (!arst_n)
    (s_enter_arr and (!is_otp(e_addr_r) && !is_pwd(e_addr_r) && row_ok_r && row_r == e_addr_r[19:5]))
    |=> (ecnt_r == {1'b0, page_w_r}))
    else $error("paged wait count wrong");

  a_pipe_gated: assert property (@(posedge clk) disable iff (!arst_n)
    ($rose(arr_en_r) && e_pf_r) |-> $past(opt_en_r, 2))
    else $error("prefetch without pipeline enable");

  a_zero_locked: assert property (@(posedge clk) disable iff (!arst_n)
    (cpu_ack_r && $past(zero_c && ce)) |-> (rdata_r == 64'h0))
    else $error("locked read returned data");

  // A reserved write outside a wake-up must leave the mode untouched
  a_mode_legal: assert property (@(posedge clk) disable iff (!arst_n)
    (pw_wr_r && pw_val_r == fop_pkg::PWR_RESERVED && !waking_r && ce) |=> $stable(pwr_r))
    else $error("reserved power mode write changed mode");

  a_mode_not_rsv: assert property (@(posedge clk) disable iff (!arst_n)
    pwr_r != fop_pkg::PWR_RESERVED)
    else $error("reserved power mode reached");

endmodule : fop_ctrl

// >>> bench/fop_array_model.sv
module fop_array_model (
  input  wire logic        clk,
  input  wire logic        arr_en,
  input  wire logic [19:0] arr_addr,
  output logic [63:0]      arr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] last_r;
  logic [63:0] word;

  // Content is a pattern of the 64-bit word address, so a wrong word shows
  assign word = {4'ha, arr_addr, 4'h5, ~arr_addr, 16'h0};
  // Outside a read the bus shows the inverse of the last word, never stale data
  assign arr_rdata = arr_en ? word : ~last_r;

  // Remember the last word driven
  always_ff @(posedge clk)
    if (arr_en)
      last_r <= word;

endmodule : fop_array_model

// >>> bench/flash_otp_read_power_pipeline_tb_top.sv
module flash_otp_read_power_pipeline_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  csm_locked = 1'b0;
  fop_pkg::fop_axi_req_t ax = '0;
  fop_pkg::fop_axi_rsp_t rsp;
  fop_pkg::fop_cpu_req_t cr = '0;
  logic                  cpu_ack;
  logic [63:0]           cpu_rdata;
  logic                  arr_en;
  logic [19:0]           arr_addr;
  logic [63:0]           arr_rdata;
  logic [1:0]            pwr_state;
  logic [63:0]           cq[$];
  logic [33:0]           aq[$];
  logic [33:0]           e;
  logic [21:0]           a;
  logic [14:0]           lrow;
  int                    error_cnt = 0;
  int                    n_tests = 0;
  int                    i;

  // Bench clock, 100 MHz
  always #5 clk = ~clk;

  fop_ctrl u_dut (
    .clk        (clk),
    .arst_n     (arst_n),
    .ce         (1'b1),
    .axi_req    (ax),
    .axi_rsp    (rsp),
    .cpu_req    (cr),
    .cpu_ack    (cpu_ack),
    .cpu_rdata  (cpu_rdata),
    .csm_locked (csm_locked),
    .arr_en     (arr_en),
    .arr_addr   (arr_addr),
    .arr_rdata  (arr_rdata),
    .pwr_state  (pwr_state)
  );

  fop_array_model u_mem (
    .clk       (clk),
    .arr_en    (arr_en),
    .arr_addr  (arr_addr),
    .arr_rdata (arr_rdata)
  );

  function automatic logic [63:0] pat(input logic [21:0] ad);
    pat = {4'ha, ad[21:2], 4'h5, ~ad[21:2], 16'h0};
  endfunction : pat

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic give_up;
    error_cnt++;
    give_verdict();
  endtask : give_up

  // One register access; the answer is checked by the monitor
  task automatic axi(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [33:0] ex);
    int n;
    @(posedge clk);
    aq.push_back(ex);
    ax.awvalid <= wr;
    ax.wvalid  <= wr;
    ax.bready  <= wr;
    ax.arvalid <= !wr;
    ax.rready  <= !wr;
    ax.awaddr  <= ad;
    ax.araddr  <= ad;
    ax.wdata   <= d;
    ax.wstrb   <= 4'hf;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (rsp.awready)
        ax.awvalid <= 1'b0;
      if (rsp.wready)
        ax.wvalid <= 1'b0;
      if (rsp.arready)
        ax.arvalid <= 1'b0;
      if (rsp.bvalid || rsp.rvalid)
        break;
    end
    ax.bready <= 1'b0;
    ax.rready <= 1'b0;
    if (n == 50)
      give_up();
  endtask : axi

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    axi(1'b1, ad, d, {fop_pkg::RESP_OKAY, 32'h0});
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [33:0] ex);
    axi(1'b0, ad, 32'h0, ex);
  endtask : rd

  // One CPU request; lat < 0 leaves the latency unchecked
  task automatic cpu(input fop_pkg::fop_kind_t k, input logic ds, input logic [21:0] ad,
                     input logic [63:0] ex, input int lat);
    int n;
    @(posedge clk);
    cq.push_back(ex);
    cr.valid <= 1'b1;
    cr.kind  <= k;
    cr.disc  <= ds;
    cr.addr  <= ad;
    for (n = 0; n < 300; n++)
    begin
      @(posedge clk);
      if (cpu_ack === 1'b1)
        break;
    end
    cr.valid <= 1'b0;
    if (n == 300)
      give_up();
    if (lat >= 0)
      chk(64'(n), 64'(lat + 1));
  endtask : cpu

  // Monitor: every answer is matched to the oldest note
  always @(posedge clk)
  begin
    if (cpu_ack === 1'b1)
      chk(cpu_rdata, cq.pop_front());
    if (rsp.bvalid === 1'b1 && ax.bready)
    begin
      e = aq.pop_front();
      chk({62'h0, rsp.bresp}, {62'h0, e[33:32]});
    end
    if (rsp.rvalid === 1'b1 && ax.rready)
      chk({30'h0, rsp.rresp, rsp.rdata}, {30'h0, aq.pop_front()});
  end

  // Main sequence
  initial
  begin
    void'($urandom(59));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    chk({62'h0, pwr_state}, {62'h0, fop_pkg::PWR_SLEEP});
    rd(8'h00, 34'h0);
    rd(8'h18, {2'h0, 32'hff});
    rd(8'h1c, {2'h0, 32'h1f});
    rd(8'h04, {fop_pkg::RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h01);
    wr(8'h1c, 32'h2);
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3f0100, pat(22'h3f0100), 2 + 3 + 4 + 2);
    chk({62'h0, pwr_state}, {62'h0, fop_pkg::PWR_ACTIVE});
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3f0104, pat(22'h3f0104), 2);
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3f7ff8, pat(22'h3f7ff8), 18);
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3d7800, pat(22'h3d7800), 4);
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3d7804, pat(22'h3d7804), 4);
    lrow = 15'h7fff;
    for (i = 0; i < 6; i++)
    begin
      a = fop_pkg::FLASH_LO | 22'($urandom() & 32'h0184);
      cpu(fop_pkg::KIND_READ, 1'b0, a, pat(a), (a[21:7] == lrow) ? 2 : 3);
      lrow = a[21:7];
    end
    cpu(fop_pkg::KIND_WRITE, 1'b0, 22'h3f0000, 64'h0, 0);
    csm_locked <= 1'b1;
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3f0200, 64'h0, 3);
    csm_locked <= 1'b0;
    wr(8'h08, 32'h0);
    rd(8'h08, 34'h0);
    wr(8'h08, 32'h2);
    rd(8'h08, 34'h0);
    wr(8'h08, 32'h3);
    repeat (8) @(posedge clk);
    rd(8'h08, {2'h0, 32'h3});
    wr(8'h08, 32'h1);
    rd(8'h08, {2'h0, 32'h1});
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3f0300, pat(22'h3f0300), 4 + 1 + 3);
    wr(8'h18, 32'h12);
    wr(8'h00, 32'h1);
    cpu(fop_pkg::KIND_FETCH, 1'b1, 22'h3f1000, pat(22'h3f1000), -1);
    repeat (20) @(posedge clk);
    cpu(fop_pkg::KIND_READ, 1'b0, 22'h3d7808, pat(22'h3d7808), 4);
    cpu(fop_pkg::KIND_FETCH, 1'b0, 22'h3f1006, pat(22'h3f1006), 0);
    cpu(fop_pkg::KIND_FETCH, 1'b1, 22'h3f2000, pat(22'h3f2000), -1);
    repeat (20) @(posedge clk);
    cpu(fop_pkg::KIND_FETCH, 1'b0, 22'h3f2004, pat(22'h3f2004), 0);
    repeat (4) @(posedge clk);
    give_verdict();
  end

endmodule : flash_otp_read_power_pipeline_tb_top
